// >>> rtl/bbmd_pkg.sv
package bbmd_pkg;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int POS_W = 5;
  localparam int OP_W = 4;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam logic [OP_W-1:0] OP_WORD_BYTE_SWAP = 4'h0;
  localparam logic [OP_W-1:0] OP_HALFWORD_PAIR_BYTE_SWAP = 4'h1;
  localparam logic [OP_W-1:0] OP_LOW_HALF_SWAP_SIGNED = 4'h2;
  localparam logic [OP_W-1:0] OP_SIGNED_LONG_MUL_ACC = 4'h3;
  localparam logic [OP_W-1:0] OP_SIGNED_LONG_MUL = 4'h4;
  localparam logic [OP_W-1:0] OP_UNSIGNED_LONG_MUL_ACC = 4'h5;
  localparam logic [OP_W-1:0] OP_UNSIGNED_LONG_MUL = 4'h6;
  localparam logic [OP_W-1:0] OP_SIGNED_HALF_WIDEN = 4'h7;
  localparam logic [OP_W-1:0] OP_ZERO_HALF_WIDEN = 4'h8;
  localparam logic [OP_W-1:0] OP_SIGNED_FIELD_EXTRACT = 4'h9;
  localparam logic [OP_W-1:0] OP_UNSIGNED_FIELD_EXTRACT = 4'ha;
  localparam logic [OP_W-1:0] OP_CARRY_ROTATE_ONE = 4'hb;
  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
endpackage

// >>> rtl/bbmd_field_extract.sv
`timescale 1ns/1ns
module bbmd_field_extract #(
  parameter int WIDTH = 32
)
(
  input wire logic [WIDTH-1:0] src_in,
  input wire logic [$clog2(WIDTH)-1:0] lsb_in,
  input wire logic [$clog2(WIDTH)-1:0] width_m1_in,
  input wire logic signed_in,
  output logic [WIDTH-1:0] field_out
);
  logic [WIDTH-1:0] shifted;
  logic top_bit;

  if (WIDTH < 2)
  begin : g_chk
    $error("bbmd_field_extract: WIDTH below 2");
  end

  always_comb
  begin
    shifted = src_in >> lsb_in;
    top_bit = shifted[width_m1_in];
  end

  // Bits above the field take zero or the field's top bit
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    assign field_out[i] = (i <= int'(width_m1_in)) ? shifted[i] : (signed_in & top_bit);
  end
endmodule

// >>> rtl/bbmd_datapath.sv
`timescale 1ns/1ns
module bbmd_datapath #(
  parameter int WIDTH = 32
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic START_IN,
  input wire logic [bbmd_pkg::OP_W-1:0] OP_IN,
  input wire logic [WIDTH-1:0] SRC_A_IN,
  input wire logic [WIDTH-1:0] SRC_B_IN,
  input wire logic [WIDTH-1:0] ACC_LOW_IN,
  input wire logic [WIDTH-1:0] ACC_HIGH_IN,
  input wire logic [1:0] ROT_SEL_IN,
  input wire logic [$clog2(WIDTH)-1:0] FIELD_LSB_IN,
  input wire logic [$clog2(WIDTH)-1:0] FIELD_WIDTH_M1_IN,
  input wire logic SET_FLAGS_IN,
  input wire logic CARRY_IN,
  output logic DONE_OUT,
  output logic WIDE_OUT,
  output logic [WIDTH-1:0] RESULT_LOW_WORD_OUT,
  output logic [WIDTH-1:0] RESULT_HIGH_WORD_OUT,
  output logic FLAGS_VALID_OUT,
  output logic NEG_FLAG_OUT,
  output logic ZERO_FLAG_OUT,
  output logic CARRY_FLAG_OUT
);
  typedef struct packed {
    logic done;
    logic wide;
    logic [WIDTH-1:0] lo;
    logic [WIDTH-1:0] hi;
    logic flags_valid;
    logic [2:0] flags;
  } bbmd_state_t;

  localparam int LANES = WIDTH / bbmd_pkg::BYTE_W;

  bbmd_state_t state_reg;
  bbmd_state_t state_next;
  logic [WIDTH-1:0] rotated;
  logic [2*WIDTH-1:0] rot_pair;
  logic [WIDTH-1:0] field;
  logic [2*WIDTH-1:0] a_sext;
  logic [2*WIDTH-1:0] b_sext;
  logic [2*WIDTH-1:0] a_zext;
  logic [2*WIDTH-1:0] b_zext;
  logic [2*WIDTH-1:0] prod_s;
  logic [2*WIDTH-1:0] prod_u;
  logic [2*WIDTH-1:0] acc;
  logic [2*WIDTH-1:0] sum_s;
  logic [2*WIDTH-1:0] sum_u;
  logic [WIDTH-1:0] carry_rotate_one;
  logic [2:0] rrx_flags;
  logic [WIDTH-1:0] word_swap;
  logic [WIDTH-1:0] half_swap;
  logic [bbmd_pkg::HALF_W-1:0] swapped_low;
  logic field_signed;

  if (WIDTH != bbmd_pkg::WORD_W)
  begin : g_chk
    $error("bbmd_datapath: only 32-bit words are served");
  end

  if (2 * bbmd_pkg::HALF_W != WIDTH || LANES * bbmd_pkg::BYTE_W != WIDTH)
  begin : g_lane_chk
    $error("bbmd_datapath: word must split into two halves of whole bytes");
  end

  // Lane i of the word swap takes the mirrored lane; the pair swap only trades neighbours
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign word_swap[i*bbmd_pkg::BYTE_W +: bbmd_pkg::BYTE_W] =
      SRC_A_IN[(LANES-1-i)*bbmd_pkg::BYTE_W +: bbmd_pkg::BYTE_W];
    assign half_swap[i*bbmd_pkg::BYTE_W +: bbmd_pkg::BYTE_W] =
      SRC_A_IN[(i^1)*bbmd_pkg::BYTE_W +: bbmd_pkg::BYTE_W];
  end

  bbmd_field_extract #(
    .WIDTH(WIDTH)
  ) u_field (
    .src_in(SRC_A_IN),
    .lsb_in(FIELD_LSB_IN),
    .width_m1_in(FIELD_WIDTH_M1_IN),
    .signed_in(field_signed),
    .field_out(field)
  );

  always_comb
  begin
    field_signed = (OP_IN == bbmd_pkg::OP_SIGNED_FIELD_EXTRACT);
    // Rotation by 0, 8, 16 or 24 ahead of the halfword widen
    rot_pair = {SRC_A_IN, SRC_A_IN} >> {ROT_SEL_IN, 3'h0};
    rotated = rot_pair[WIDTH-1:0];
    // Both operands are widened to 64 bits first so the product keeps its upper word
    a_sext = {{WIDTH{SRC_A_IN[WIDTH-1]}}, SRC_A_IN};
    b_sext = {{WIDTH{SRC_B_IN[WIDTH-1]}}, SRC_B_IN};
    a_zext = {{WIDTH{1'b0}}, SRC_A_IN};
    b_zext = {{WIDTH{1'b0}}, SRC_B_IN};
    prod_s = a_sext * b_sext;
    prod_u = a_zext * b_zext;
    acc = {ACC_HIGH_IN, ACC_LOW_IN};
    // Carry out of the top word is dropped: the pair wraps modulo 2 to the 64
    sum_s = prod_s + acc;
    sum_u = prod_u + acc;
    carry_rotate_one = {CARRY_IN, SRC_A_IN[WIDTH-1:1]};
    rrx_flags[bbmd_pkg::FLAG_N] = carry_rotate_one[WIDTH-1];
    rrx_flags[bbmd_pkg::FLAG_Z] = (carry_rotate_one == '0);
    rrx_flags[bbmd_pkg::FLAG_C] = SRC_A_IN[0];
    swapped_low = half_swap[bbmd_pkg::HALF_W-1:0];
    // Results hold until the next taken request; flags until the next flag-setting carry rotate
    state_next = state_reg;
    state_next.done = START_IN;
    state_next.flags_valid = 1'b0;
    if (START_IN)
    begin
      state_next.wide = 1'b0;
      // 32-bit results leave the high word at zero
      state_next.hi = '0;
      case (OP_IN)
        bbmd_pkg::OP_WORD_BYTE_SWAP:
        begin
          state_next.lo = word_swap;
        end
        bbmd_pkg::OP_HALFWORD_PAIR_BYTE_SWAP:
        begin
          state_next.lo = half_swap;
        end
        bbmd_pkg::OP_LOW_HALF_SWAP_SIGNED:
        begin
          state_next.lo = {{16{swapped_low[15]}}, swapped_low};
        end
        bbmd_pkg::OP_SIGNED_LONG_MUL_ACC:
        begin
          state_next.wide = 1'b1;
          {state_next.hi, state_next.lo} = sum_s;
        end
        bbmd_pkg::OP_SIGNED_LONG_MUL:
        begin
          state_next.wide = 1'b1;
          {state_next.hi, state_next.lo} = prod_s;
        end
        bbmd_pkg::OP_UNSIGNED_LONG_MUL_ACC:
        begin
          state_next.wide = 1'b1;
          {state_next.hi, state_next.lo} = sum_u;
        end
        bbmd_pkg::OP_UNSIGNED_LONG_MUL:
        begin
          state_next.wide = 1'b1;
          {state_next.hi, state_next.lo} = prod_u;
        end
        bbmd_pkg::OP_SIGNED_HALF_WIDEN:
        begin
          state_next.lo = {{16{rotated[15]}}, rotated[15:0]};
        end
        bbmd_pkg::OP_ZERO_HALF_WIDEN:
        begin
          state_next.lo = {16'h0000, rotated[15:0]};
        end
        bbmd_pkg::OP_SIGNED_FIELD_EXTRACT,
        bbmd_pkg::OP_UNSIGNED_FIELD_EXTRACT:
        begin
          state_next.lo = field;
        end
        bbmd_pkg::OP_CARRY_ROTATE_ONE:
        begin
          state_next.lo = carry_rotate_one;
          if (SET_FLAGS_IN)
          begin
            state_next.flags_valid = 1'b1;
            state_next.flags = rrx_flags;
          end
        end
        default:
        begin
          // Unknown codes still pulse done, with a zero result
          state_next.lo = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_reg <= '{done: 1'b0, wide: 1'b0, lo: bbmd_pkg::RESULT_RESET,
                     hi: bbmd_pkg::RESULT_RESET, flags_valid: 1'b0,
                     flags: bbmd_pkg::FLAGS_RESET};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign DONE_OUT = state_reg.done;
  assign WIDE_OUT = state_reg.wide;
  assign RESULT_LOW_WORD_OUT = state_reg.lo;
  assign RESULT_HIGH_WORD_OUT = state_reg.hi;
  assign FLAGS_VALID_OUT = state_reg.flags_valid;
  assign NEG_FLAG_OUT = state_reg.flags[bbmd_pkg::FLAG_N];
  assign ZERO_FLAG_OUT = state_reg.flags[bbmd_pkg::FLAG_Z];
  assign CARRY_FLAG_OUT = state_reg.flags[bbmd_pkg::FLAG_C];
endmodule

// >>> testbench/bbmd_decode_model.sv
`timescale 1ns/1ns
module bbmd_decode_model
(
  input wire logic clk_in,
  output logic st_out,
  output logic [3:0] op_out,
  output logic [31:0] a_out,
  output logic [31:0] b_out,
  output logic [31:0] lo_out,
  output logic [31:0] hi_out,
  output logic [11:0] imm_out,
  output logic [1:0] fl_out
);
  initial {st_out, op_out, a_out, b_out, lo_out, hi_out, imm_out, fl_out} = '0;
  // Immediates are {rotate, field start, width minus one}; fields stay inside bit 31
  task req(input logic [3:0] o, input logic [31:0] a, b, l, h, input logic [11:0] m,
    input logic [1:0] f);
    @(posedge clk_in);
    #1;
    {st_out, op_out, a_out, b_out, lo_out, hi_out, imm_out, fl_out} = {1'b1, o, a, b, l, h, m, f};
  endtask
  // Released operands are scrambled so stale values cannot pass
  task stop();
    @(posedge clk_in);
    #1;
    {st_out, a_out, b_out} = {1'b0, ~a_out, ~b_out};
  endtask
endmodule

// >>> testbench/bbmd_datapath_sva.sv
`timescale 1ns/1ns
module bbmd_datapath_sva
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic START_IN,
  input wire logic [3:0] OP_IN,
  input wire logic [31:0] SRC_A_IN,
  input wire logic [31:0] SRC_B_IN,
  input wire logic SET_FLAGS_IN,
  input wire logic CARRY_IN,
  input wire logic DONE_OUT,
  input wire logic WIDE_OUT,
  input wire logic [31:0] RESULT_LOW_WORD_OUT,
  input wire logic [31:0] RESULT_HIGH_WORD_OUT,
  input wire logic FLAGS_VALID_OUT,
  input wire logic NEG_FLAG_OUT,
  input wire logic ZERO_FLAG_OUT,
  input wire logic CARRY_FLAG_OUT
);
  wire [63:0] r = {RESULT_HIGH_WORD_OUT, RESULT_LOW_WORD_OUT};
  wire [31:0] a = SRC_A_IN;
  wire [31:0] b = SRC_B_IN;
  wire [31:0] sw = {a[7:0], a[15:8], a[23:16], a[31:24]};
  wire [63:0] um = {32'h0, a} * {32'h0, b};
  wire [63:0] sm = {{32{a[31]}}, a} * {{32{b[31]}}, b};
  wire [2:0] fl = {NEG_FLAG_OUT, ZERO_FLAG_OUT, CARRY_FLAG_OUT};
  wire rf = START_IN && OP_IN == 4'hb && SET_FLAGS_IN;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  a_done_pulse: assert property (DONE_OUT == $past(START_IN)) else $error("done timing");
  a_word_swap: assert property (START_IN && OP_IN == 4'h0 |=> r == {32'h0, $past(sw)})
    else $error("word swap");
  a_signed_mul: assert property (START_IN && OP_IN == 4'h4 |=> WIDE_OUT && r == $past(sm))
    else $error("signed mul");
  a_unsigned_mul: assert property (START_IN && OP_IN == 4'h6 |=> r == $past(um))
    else $error("unsigned mul");
  a_half_sign: assert property (START_IN && OP_IN == 4'h7 |=> r[63:16] == {{32'h0}, {16{r[15]}}})
    else $error("half sign");
  a_low_swap: assert property (START_IN && OP_IN == 4'h2 |=>
    r == {32'h0, {16{$past(a[7])}}, $past(a[7:0]), $past(a[15:8])}) else $error("low swap");
  a_half_zero: assert property (START_IN && OP_IN == 4'h8 |=> r[63:16] == 48'h0)
    else $error("half zero");
  a_rot_carry: assert property (START_IN && OP_IN == 4'hb |=>
    r == {32'h0, $past(CARRY_IN), $past(a[31:1])}) else $error("rotate carry");
  a_rot_flags: assert property (rf |=> FLAGS_VALID_OUT &&
    fl == {$past(CARRY_IN), {$past(CARRY_IN), $past(a[31:1])} == 32'h0, $past(a[0])})
    else $error("rotate flags");
  a_flags_hold: assert property (START_IN && !rf |=> !FLAGS_VALID_OUT && $stable(fl))
    else $error("flags hold");
  cover property (START_IN && OP_IN == 4'h3);
  cover property (rf);
  cover property (START_IN ##1 START_IN);
endmodule

// >>> testbench/bit_byte_multiply_datapath_test.sv
`timescale 1ns/1ns
module bit_byte_multiply_datapath_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wire st, dn, wd, fv, ng, zr, cf;
  wire [3:0] op;
  wire [31:0] a, b, l, h, lo, hi;
  wire [11:0] im;
  wire [1:0] fl;
  int err_total = 0;
  int tests_run = 0;
  logic [69:0] pend;
  always #50 clk = ~clk;
  bbmd_decode_model dec (.clk_in(clk), .st_out(st), .op_out(op), .a_out(a), .b_out(b),
    .lo_out(l), .hi_out(h), .imm_out(im), .fl_out(fl));
  bbmd_datapath dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .START_IN(st), .OP_IN(op),
    .SRC_A_IN(a), .SRC_B_IN(b), .ACC_LOW_IN(l), .ACC_HIGH_IN(h), .ROT_SEL_IN(im[11:10]),
    .FIELD_LSB_IN(im[9:5]), .FIELD_WIDTH_M1_IN(im[4:0]), .SET_FLAGS_IN(fl[1]),
    .CARRY_IN(fl[0]), .DONE_OUT(dn), .WIDE_OUT(wd), .RESULT_LOW_WORD_OUT(lo),
    .RESULT_HIGH_WORD_OUT(hi), .FLAGS_VALID_OUT(fv), .NEG_FLAG_OUT(ng),
    .ZERO_FLAG_OUT(zr), .CARRY_FLAG_OUT(cf));
  task chk(input string n, input logic [69:0] e);
    tests_run++;
    if ({dn, wd, fv, ng, zr, cf, hi, lo} !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, {dn, wd, fv, ng, zr, cf, hi, lo});
    end
  endtask
  // Flags nibble is {valid, N, Z, C}; each call judges the request taken one edge before
  task run(input logic [3:0] o, input logic [31:0] x, y, input logic [3:0] f4,
    input logic [63:0] e, input logic [11:0] m = 12'h0, input logic [1:0] f = 2'h0,
    input logic [31:0] al = 32'h0, ah = 32'h0);
    dec.req(o, x, y, al, ah, m, f);
    if (pend[69])
      chk("result", pend);
    pend = {1'b1, (o inside {[4'h3:4'h6]}), f4, e};
  endtask
  task flush();
    dec.stop();
    chk("result", pend);
    @(posedge clk);
    #1;
    chk("idle", {1'b0, pend[68], 1'b0, pend[66:0]});
    pend = '0;
  endtask
  task t_swaps();
    run(4'h0, 32'h1122_3344, 32'h0, 4'h0, 64'h4433_2211);
    run(4'h1, 32'h1122_3344, 32'h0, 4'h0, 64'h2211_4433);
    run(4'h2, 32'h1234_0080, 32'h0, 4'h0, 64'hffff_8000);
    flush();
  endtask
  task t_muls();
    run(4'h4, 32'hffff_fffe, 32'h3, 4'h0, 64'hffff_ffff_ffff_fffa);
    run(4'h6, 32'hffff_fffe, 32'h3, 4'h0, 64'h2_ffff_fffa);
    run(4'h3, 32'hffff_fffe, 32'h3, 4'h0, 64'ha, 12'h0, 2'h0, 32'h10);
    run(4'h5, 32'hffff_fffe, 32'h3, 4'h0, 64'h2_0000_000a, 12'h0, 2'h0, 32'h10, 32'hffff_ffff);
    flush();
  endtask
  task t_widen_extract();
    run(4'h7, 32'h0000_8001, 32'h0, 4'h0, 64'hffff_8001);
    run(4'h8, 32'h0080_0100, 32'h0, 4'h0, 64'h8001, 12'h400);
    run(4'h7, 32'h8001_7fff, 32'h0, 4'h0, 64'hffff_8001, 12'h800);
    run(4'h9, 32'hf000_0000, 32'h0, 4'h0, 64'hffff_ffff, 12'h383);
    run(4'ha, 32'hf000_0000, 32'h0, 4'h0, 64'hf, 12'h383);
    run(4'h9, 32'h0000_0a50, 32'h0, 4'h0, 64'hffff_ffa5, 12'h087);
    run(4'ha, 32'h0000_0a50, 32'h0, 4'h0, 64'ha5, 12'h087);
    run(4'h7, 32'h1234_5689, 32'h0, 4'h0, 64'hffff_8912, 12'hc00);
    run(4'h9, 32'h8000_0001, 32'h0, 4'h0, 64'h8000_0001, 12'h01f);
    flush();
  endtask
  task t_rotate();
    run(4'hb, 32'h1, 32'h0, 4'hb, 64'h0, 12'h0, 2'h2);
    run(4'hb, 32'h8000_0000, 32'h0, 4'h3, 64'hc000_0000, 12'h0, 2'h1);
    run(4'hf, 32'h1234_5678, 32'h0, 4'h3, 64'h0);
    flush();
  endtask
  task t_reset_mid();
    run(4'hb, 32'h2, 32'h0, 4'hc, 64'h8000_0001, 12'h0, 2'h3);
    flush();
    rst_b = 1'b0;
    #1;
    chk("reset", 70'h0);
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("reset", 70'h0);
    run(4'h0, 32'haabb_ccdd, 32'h0, 4'h0, 64'hddcc_bbaa);
    flush();
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    pend = '0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("reset", 70'h0);
    t_swaps();
    t_muls();
    t_widen_extract();
    t_rotate();
    t_reset_mid();
    report_and_stop();
  end
endmodule
bind bbmd_datapath bbmd_datapath_sva chk_i (.CLK_SYS_IN, .RST_B_IN, .START_IN, .OP_IN,
  .SRC_A_IN, .SRC_B_IN, .SET_FLAGS_IN, .CARRY_IN, .DONE_OUT, .WIDE_OUT,
  .RESULT_LOW_WORD_OUT, .RESULT_HIGH_WORD_OUT, .FLAGS_VALID_OUT, .NEG_FLAG_OUT,
  .ZERO_FLAG_OUT, .CARRY_FLAG_OUT);
